//--- pkg/tdsr_defines.vh
`ifndef TDSR_DEFINES_VH
`define TDSR_DEFINES_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define TDSR_ADR_CTRL 8'h00
`define TDSR_ADR_STAT 8'h04
`define TDSR_ADR_FULL 8'h08
`define TDSR_ADR_HALF 8'h0c
`define TDSR_ADR_DATA 8'h10

// ****************************************
// Field positions
// ****************************************
`define TDSR_CTRL_ARM 0
`define TDSR_CTRL_POL 1
`define TDSR_CTRL_CNT_LO 8
`define TDSR_STAT_DONE 0
`define TDSR_STAT_ERR 1
`define TDSR_STAT_CMPL 2
`define TDSR_STAT_FRAME 3
`define TDSR_STAT_IE 4
`define TDSR_STAT_EVT 5
`define TDSR_STAT_ST_LO 8
`define TDSR_ST_UNVER 7
`define TDSR_ST_UNDET 6

// ****************************************
// Reset and load values
// ****************************************
`define TDSR_ARM_TIMER 8'hff
`define TDSR_BITS_RST 6'h0b
`define TDSR_FULL_RST 8'h8e
`define TDSR_HALF_RST 8'hc7

// ****************************************
// Timing
// ****************************************
`define TDSR_CLK_NS 10
`define TDSR_STEP_NS 80000
`define TDSR_STEP_CYC (`TDSR_STEP_NS / `TDSR_CLK_NS)

`endif

//--- core/tdsr_receiver.v
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "tdsr_defines.vh"

module tdsr_receiver #(
  parameter STEP_CYCLES = `TDSR_STEP_CYC,
  parameter DATA_W = 32
) (
  input wire ref_clk, // System clock
  input wire reset, // Async reset, active high
  input wire wb_cyc_i, // Bus cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write enable
  input wire [7:0] wb_adr_i, // Byte address
  input wire [3:0] wb_sel_i, // Byte lanes
  input wire [31:0] wb_dat_i, // Write data
  output reg [31:0] wb_dat_o, // Read data
  output reg wb_ack_o, // Acknowledge
  input wire rx_line, // Serial receive line
  output reg line_polarity_select, // Polarity bit out
  output reg timer_overflow // Overflow pulse
);

  // ****************************************
  // Functions
  // ****************************************
  function [7:0] lane_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input en;
    begin
      lane_merge = en ? new_v : old_v;
    end
  endfunction

  function hit;
    input [7:0] adr;
    input [7:0] ref_adr;
    begin
      hit = (adr[7:2] == ref_adr[7:2]);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [15:0] presc_ff;
  reg [7:0] timer_ff;
  reg event_mode_ff;
  reg ovf_ie_ff;
  reg [7:0] state_ff;
  reg done_ff;
  reg err_ff;
  reg cmpl_ff;
  reg frame_ff;
  reg [7:0] full_ff;
  reg [7:0] half_ff;
  reg [5:0] bits_ff;
  reg [DATA_W-1:0] data_ff;
  reg test_prev_ff;

  reg [7:0] nxt_timer;
  reg nxt_event_mode;
  reg nxt_ie;
  reg [7:0] nxt_state;
  reg nxt_done;
  reg nxt_err;
  reg nxt_cmpl;
  reg nxt_frame;
  reg nxt_pol;
  reg [DATA_W-1:0] nxt_data;
  reg nxt_ovf;

  wire bus_req;
  wire wr_stb;
  wire gated_test_input;
  wire step_tick;
  wire test_fall;
  wire timer_inc;
  wire wrap;
  wire service;
  wire arm;
  wire wr_ctrl;
  wire wr_stat;
  wire [5:0] cnt_left;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = bus_req & wb_we_i;
  assign wr_ctrl = wr_stb & hit(wb_adr_i, `TDSR_ADR_CTRL);
  assign wr_stat = wr_stb & hit(wb_adr_i, `TDSR_ADR_STAT);
  assign arm = wr_ctrl & wb_sel_i[0] & wb_dat_i[`TDSR_CTRL_ARM];

  // ****************************************
  // Edge gate and time base
  // ****************************************
  // Polarity one makes the test input follow the line
  assign gated_test_input = ~(rx_line ^ line_polarity_select);
  // With polarity one, mark to space on the line is a falling test input
  assign test_fall = test_prev_ff & ~gated_test_input;
  assign step_tick = (presc_ff == STEP_CYCLES[15:0] - 16'h0001);
  assign timer_inc = event_mode_ff ? test_fall : step_tick;
  assign wrap = timer_inc & (timer_ff == 8'hff);
  // Wrap with overflow enabled drives one service step
  assign service = wrap & ovf_ie_ff;
  assign cnt_left = state_ff[5:0];

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      presc_ff <= 16'h0000;
      test_prev_ff <= 1'b1;
    end
    else
    begin
      test_prev_ff <= gated_test_input;
      // Prescaler runs only in timer mode so half bit starts clean
      if (event_mode_ff | step_tick)
        presc_ff <= 16'h0000;
      else
        presc_ff <= presc_ff + 16'h0001;
    end
  end

  // ****************************************
  // Receive sequence
  // ****************************************
  always @*
  begin
    nxt_timer = timer_inc ? timer_ff + 8'h01 : timer_ff;
    nxt_event_mode = event_mode_ff;
    nxt_ie = ovf_ie_ff;
    nxt_state = state_ff;
    nxt_done = done_ff;
    nxt_err = err_ff;
    nxt_cmpl = cmpl_ff;
    nxt_frame = frame_ff;
    nxt_pol = line_polarity_select;
    nxt_data = data_ff;
    nxt_ovf = wrap;
    // Software clear first, so a hardware set below wins
    if (wr_stat & wb_sel_i[0])
    begin
      if (wb_dat_i[`TDSR_STAT_ERR])
        nxt_err = 1'b0;
      if (wb_dat_i[`TDSR_STAT_CMPL])
        nxt_cmpl = 1'b0;
      if (wb_dat_i[`TDSR_STAT_FRAME])
        nxt_frame = 1'b0;
    end
    if (wr_ctrl & wb_sel_i[0])
      nxt_pol = wb_dat_i[`TDSR_CTRL_POL];
    if (service)
    begin
      if (state_ff[`TDSR_ST_UNVER])
      begin
        if (state_ff[`TDSR_ST_UNDET])
        begin
          nxt_timer = half_ff;
          nxt_event_mode = 1'b0;
          nxt_state[`TDSR_ST_UNDET] = 1'b0;
        end
        else if (!rx_line)
        begin
          nxt_timer = full_ff;
          nxt_state[`TDSR_ST_UNVER] = 1'b0;
        end
        else
        begin
          nxt_err = 1'b1;
          // Re-arm for the next start edge
          nxt_timer = `TDSR_ARM_TIMER;
          nxt_event_mode = 1'b1;
          nxt_state = {2'b11, bits_ff};
          nxt_pol = 1'b1;
        end
      end
      else
      begin
        nxt_timer = full_ff;
        nxt_data = {data_ff[DATA_W-2:0], rx_line};
        nxt_state[5:0] = cnt_left - 6'h01;
        if (cnt_left == 6'h01)
        begin
          nxt_done = 1'b0;
          nxt_ie = 1'b0;
          nxt_cmpl = 1'b1;
          // Last sample is the stop bit; space means framing fault
          if (!rx_line)
            nxt_frame = 1'b1;
        end
      end
    end
    // Arm overrides a coincident service step's timer, mode, state, done, ie and pol; err, cmpl, frame and data keep its update
    if (arm)
    begin
      nxt_ie = 1'b0;
      nxt_pol = 1'b1;
      nxt_timer = `TDSR_ARM_TIMER;
      nxt_event_mode = 1'b1;
      nxt_done = 1'b1;
      nxt_state = {2'b11, bits_ff};
      // Overflow re-enabled last, once the timer is loaded
      nxt_ie = 1'b1;
    end
  end

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      timer_ff <= 8'h00;
      event_mode_ff <= 1'b0;
      ovf_ie_ff <= 1'b0;
      state_ff <= 8'h00;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      cmpl_ff <= 1'b0;
      frame_ff <= 1'b0;
      line_polarity_select <= 1'b0;
      data_ff <= {DATA_W{1'b0}};
      timer_overflow <= 1'b0;
    end
    else
    begin
      timer_ff <= nxt_timer;
      event_mode_ff <= nxt_event_mode;
      ovf_ie_ff <= nxt_ie;
      state_ff <= nxt_state;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      cmpl_ff <= nxt_cmpl;
      frame_ff <= nxt_frame;
      line_polarity_select <= nxt_pol;
      data_ff <= nxt_data;
      timer_overflow <= nxt_ovf;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      full_ff <= `TDSR_FULL_RST;
      half_ff <= `TDSR_HALF_RST;
      bits_ff <= `TDSR_BITS_RST;
    end
    else
    begin
      // Baud rate is set by the two reload values
      if (wr_stb & hit(wb_adr_i, `TDSR_ADR_FULL))
        full_ff <= lane_merge(full_ff, wb_dat_i[7:0], wb_sel_i[0]);
      if (wr_stb & hit(wb_adr_i, `TDSR_ADR_HALF))
        half_ff <= lane_merge(half_ff, wb_dat_i[7:0], wb_sel_i[0]);
      // Count of zero would wrap to 63 and take 64 samples; it is kept as one
      if (wr_ctrl & wb_sel_i[1])
      begin
        if (wb_dat_i[13:8] == 6'h00)
          bits_ff <= 6'h01;
        else
          bits_ff <= wb_dat_i[13:8];
      end
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req & ~wb_we_i)
      begin
        case ({2'b00, wb_adr_i[7:2]})
          `TDSR_ADR_CTRL >> 2:
            wb_dat_o <= {18'h0, bits_ff, 6'h00, line_polarity_select, 1'b0};
          `TDSR_ADR_STAT >> 2:
            wb_dat_o <= {16'h0000, state_ff, 2'b00, event_mode_ff, ovf_ie_ff,
                         frame_ff, cmpl_ff, err_ff, done_ff};
          `TDSR_ADR_FULL >> 2:
            wb_dat_o <= {24'h000000, full_ff};
          `TDSR_ADR_HALF >> 2:
            wb_dat_o <= {24'h000000, half_ff};
          `TDSR_ADR_DATA >> 2:
            wb_dat_o <= data_ff[31:0];
          default:
            wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // tdsr_receiver

//--- tb/tdsr_receiver_properties.sv
`timescale 1ns/1ps
`include "tdsr_defines.vh"
module tdsr_receiver_chk #(
  parameter STEP_CYCLES = 4
) (
  input wire ref_clk, // Clock
  input wire reset, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [7:0] wb_adr_i, // Address
  input wire [3:0] wb_sel_i, // Lanes
  input wire [31:0] wb_dat_i, // Write data
  input wire wb_ack_o, // Ack
  input wire rx_line, // Line
  input wire line_polarity_select, // Polarity
  input wire timer_overflow // Overflow
);
  // Gap checks assume the reloads keep their reset values
  localparam int HALF_CYC = (256 - `TDSR_HALF_RST) * STEP_CYCLES;
  localparam int FULL_CYC = (256 - `TDSR_FULL_RST) * STEP_CYCLES;
  logic [15:0] gap_ff;
  logic [3:0] phase_ff;
  logic armed_ff;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ctrl_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h00;
  wire arm_wr = ctrl_wr && wb_dat_i[`TDSR_CTRL_ARM];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ****
  // Overflow phase and spacing
  // ****
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      gap_ff <= 16'h0000;
      phase_ff <= 4'h0;
      armed_ff <= 1'b0;
    end
    else
    begin
      gap_ff <= timer_overflow ? 16'h0001 : gap_ff + 16'h0001;
      armed_ff <= arm_wr | (armed_ff & ~timer_overflow);
      if (arm_wr)
        phase_ff <= 4'h1;
      else if (timer_overflow && phase_ff != 4'h0 && phase_ff != 4'hf)
        phase_ff <= phase_ff + 4'h1;
    end
  end
  sequence s_req;
    req;
  endsequence
  sequence s_ack1;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK: assert property (s_req |=> s_ack1)
    else $error("ack not one pulse after request");
  AST_POL_ARM: assert property (arm_wr |=> line_polarity_select)
    else $error("arm left polarity low");
  AST_POL_RW: assert property (
    ctrl_wr && !wb_dat_i[0] |=> line_polarity_select == $past(wb_dat_i[1]))
    else $error("polarity bit not written");
  AST_EDGE: assert property (
    armed_ff && line_polarity_select && $fell(rx_line) |-> ##[1:4] timer_overflow)
    else $error("start edge gave no overflow");
  AST_OVF_PULSE: assert property (timer_overflow |=> !timer_overflow)
    else $error("overflow longer than one cycle");
  AST_HALF: assert property (
    timer_overflow && phase_ff == 4'h2 |-> gap_ff >= HALF_CYC - 1 && gap_ff <= HALF_CYC + 1)
    else $error("half bit interval wrong");
  AST_FULL: assert property (
    timer_overflow && phase_ff inside {[4'h3:4'hd]} |-> gap_ff >= FULL_CYC - 1 && gap_ff <= FULL_CYC + 1)
    else $error("full bit interval wrong");
  AST_RST: assert property ($fell(reset) |-> !line_polarity_select && !timer_overflow && !wb_ack_o)
    else $error("outputs not idle after reset");
endmodule // tdsr_receiver_chk
bind tdsr_receiver tdsr_receiver_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.ref_clk(ref_clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .rx_line(rx_line), .line_polarity_select(line_polarity_select),
  .timer_overflow(timer_overflow));

//--- tb/tdsr_tx_model.sv
`timescale 1ns/1ps
module tdsr_tx_model #(
  parameter BIT_CYC = 456
) (
  input wire ref_clk, // Clock
  output logic rx_line // Serial line
);
  initial rx_line = 1'b1;
  // Sends n bits, first bit first, then idles at mark
  task automatic send(input logic [15:0] b, input int n, input int len);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= b[i];
      repeat (len) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
  endtask
endmodule // tdsr_tx_model

//--- tb/tdsr_receiver_bench.sv
`timescale 1ns/1ps
`include "tdsr_defines.vh"
module tdsr_receiver_bench;
  localparam int STEP = 4;
  localparam int BIT_CYC = (256 - `TDSR_FULL_RST) * STEP;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  wire [31:0] rdat;
  wire ack, rx, pol, ovf;
  int err_count = 0;
  int n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  tdsr_receiver #(.STEP_CYCLES(STEP)) u_tdsr_receiver (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_line(rx), .line_polarity_select(pol), .timer_overflow(ovf));
  tdsr_tx_model #(.BIT_CYC(BIT_CYC)) u_tdsr_tx_model (.ref_clk(ref_clk), .rx_line(rx));
  // ****
  // Shared tasks
  // ****
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    i = 0;
    // Ack and read data are taken at the rising edge that samples ack high
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1)
    begin
      err_count++;
      end_of_test;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wait_ovf(input int n);
    int i;
    i = 0;
    while (n > 0 && i < 20000)
    begin
      @(negedge ref_clk);
      i++;
      if (ovf === 1'b1)
        n--;
    end
    if (n > 0)
    begin
      err_count++;
      end_of_test;
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset_values;
    rd_chk(`TDSR_ADR_CTRL, 32'h0000_0b00);
    rd_chk(`TDSR_ADR_STAT, 32'h0);
    rd_chk(`TDSR_ADR_FULL, {24'h0, `TDSR_FULL_RST});
    rd_chk(`TDSR_ADR_HALF, {24'h0, `TDSR_HALF_RST});
    rd_chk(8'h14, 32'h0);
    bus(1'b1, `TDSR_ADR_CTRL, 32'h0b02);
    chk({31'h0, pol}, 32'h1);
    bus(1'b1, `TDSR_ADR_CTRL, 32'h0b00);
    chk({31'h0, pol}, 32'h0);
  endtask
  task automatic t_good_frame;
    logic [11:0] f;
    logic [31:0] e;
    f = 12'heb4;
    e = 32'h0;
    bus(1'b1, `TDSR_ADR_CTRL, 32'h0b03);
    chk({31'h0, pol}, 32'h1);
    rd_chk(`TDSR_ADR_STAT, 32'hcb31);
    fork
      u_tdsr_tx_model.send({4'h0, f}, 12, BIT_CYC);
      wait_ovf(13);
    join
    rd_chk(`TDSR_ADR_STAT, 32'h0004);
    for (int i = 1; i < 12; i++)
      e = {e[30:0], f[i]};
    bus(1'b0, `TDSR_ADR_DATA, 32'h0);
    chk(q & 32'h7ff, e);
  endtask
  task automatic t_bad_start;
    bus(1'b1, `TDSR_ADR_STAT, 32'h4);
    bus(1'b1, `TDSR_ADR_CTRL, 32'h0b03);
    // Low for a quarter bit, so the line is mark at mid start bit
    fork
      u_tdsr_tx_model.send(16'h0, 1, BIT_CYC / 4);
      wait_ovf(2);
    join
    rd_chk(`TDSR_ADR_STAT, 32'hcb33);
    bus(1'b1, `TDSR_ADR_STAT, 32'h2);
    rd_chk(`TDSR_ADR_STAT, 32'hcb31);
    bus(1'b1, `TDSR_ADR_CTRL, 32'h0b03);
    fork
      u_tdsr_tx_model.send(16'h06b4, 12, BIT_CYC);
      wait_ovf(13);
    join
    rd_chk(`TDSR_ADR_STAT, 32'h000c);
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_values;
    t_good_frame;
    t_bad_start;
    end_of_test;
  end
endmodule // tdsr_receiver_bench
